/* include/povc_consts.svh */
// Purpose: constants for the pll override and oscillator calibration control block
// Assumes: 10 MHz register clock, byte wide register port
// Notes:   offsets are byte addresses of the serial register map
// Functional notes
// - override enable 0 uses pins; 1 uses register override fields.
// - d select codes: 0 off, 1 divide 1, 2 divide 2, 3 divide 4.
// - d select acts only in override mode; otherwise pins decide.
// - d output never clocks unless c output is clocking.
// - c select codes: 0 off, 1 divide 1, 2 divide 2, 3 divide 4.
// - c select acts only in override mode; otherwise pins decide.
// - override mode: reference-type bit 1 picks single-ended reference input.
// - override mode: pll-enable bit 1 enables the pll.
// - seven-bit trim field, overwritten by the calibration result.
// - trim readable after calibration and may be written back later.
// - three-bit settle field, default 4, longer wait for larger values.
// - calibration starts when programming reset written 0 with enable set.
// - calibration tunes trim to centre the oscillator frequency.
// - done status reads 1 after completion or when calibration skipped.
`ifndef POVC_CONSTS_SVH
`define POVC_CONSTS_SVH

// ****************************************
// register offsets
// ****************************************
`define POVC_OFS_OVERRIDE     8'h58
`define POVC_OFS_TRIM         8'h59
`define POVC_OFS_PROG_RESET   8'h5c
`define POVC_OFS_CAL_CTRL     8'h5d
`define POVC_OFS_CAL_STATUS   8'h5e

// ****************************************
// reset values
// ****************************************
`define POVC_RST_OVERRIDE     8'h00
`define POVC_RST_TRIM         7'h00
`define POVC_RST_PROG_RESET   1'b0
`define POVC_RST_CAL_CTRL     8'h40

// ****************************************
// field positions
// ****************************************
`define POVC_OVR_EN_BIT       7
`define POVC_OVR_D_HI         5
`define POVC_OVR_D_LO         4
`define POVC_OVR_C_HI         3
`define POVC_OVR_C_LO         2
`define POVC_OVR_SE_BIT       1
`define POVC_OVR_PLL_EN_BIT   0
`define POVC_CAL_STL_HI       6
`define POVC_CAL_STL_LO       4
`define POVC_CAL_EN_BIT       0
`define POVC_TRIM_MSB         6

// ****************************************
// timing
// ****************************************
`define POVC_CLK_PERIOD_NS    100
`define POVC_SETTLE_UNIT_NS   1000
`define POVC_SETTLE_UNIT_CYC  ((`POVC_SETTLE_UNIT_NS + `POVC_CLK_PERIOD_NS - 1) / `POVC_CLK_PERIOD_NS)

`endif

/* include/povc_pkg.sv */
// Purpose: types for the pll override and oscillator calibration control block
// Assumes: nothing
// Notes:   register port request travels as one struct
package povc_pkg;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } povc_req_s;

  typedef enum logic [1:0] {
    POVC_REF_OFF,
    POVC_REF_DIV1,
    POVC_REF_DIV2,
    POVC_REF_DIV4
  } povc_div_e;

endpackage

/* design/povc_ctrl.sv */
// Purpose: pin override selection, programming reset and oscillator trim calibration
// Assumes: register port decoded from the serial interface, inputs synchronous
// Notes:   analog pll, dividers and frequency comparator sit outside
`timescale 1ns/1ps
`default_nettype none
`include "povc_consts.svh"

module povc_ctrl (
  input  wire logic              clock_in,
  input  wire logic              resetn_in,
  input  wire povc_pkg::povc_req_s reg_req_in,
  output logic [7:0]             reg_rdata_out,
  input  wire logic              pll_enable_pin_in,
  input  wire logic              ref_single_ended_pin_in,
  input  wire logic              clock_cfg_pin_0_in,
  input  wire logic              clock_cfg_pin_1_in,
  input  wire logic              osc_too_fast_in,
  output logic                   pll_enable_out,
  output logic                   ref_single_ended_sel_out,
  output logic [1:0]             ref_out_c_div_sel_out,
  output logic [1:0]             ref_out_d_div_sel_out,
  output logic [6:0]             osc_freq_trim_out,
  output logic                   pll_program_reset_out,
  output logic                   osc_cal_busy_out,
  output logic                   osc_cal_done_out
);

  typedef enum logic [1:0] {
    POVC_ST_IDLE,
    POVC_ST_SETTLE,
    POVC_ST_EVAL,
    POVC_ST_DONE
  } povc_state_e;

  localparam int unsigned SETTLE_UNIT = `POVC_SETTLE_UNIT_CYC;

  logic [7:0]   override_r;
  logic [6:0]   osc_freq_trim_field_r;
  logic         pll_program_reset_bit_r;
  logic [7:0]   osc_cal_control_reg_r;
  logic         osc_cal_done_r;
  povc_state_e  state_r;
  logic [2:0]   bit_idx_r;
  logic [10:0]  settle_cnt_r;
  logic [7:0]   rdata_r;
  logic [7:0]   pll_out_r;

  logic         wr_override;
  logic         wr_trim;
  logic         wr_prog_reset;
  logic         wr_cal_ctrl;
  logic         cal_start;
  logic         cal_skip;
  logic         osc_cal_enable;
  logic [2:0]   osc_cal_settle_sel;
  logic [10:0]  settle_len;
  logic         pll_cfg_override_en;
  logic [1:0]   pin_c_sel;
  logic [1:0]   pin_d_sel;
  logic [1:0]   c_sel;
  logic [1:0]   d_sel;

  // ****************************************
  // register decode
  // ****************************************
  assign wr_override   = reg_req_in.wr && (reg_req_in.addr == `POVC_OFS_OVERRIDE);
  assign wr_trim       = reg_req_in.wr && (reg_req_in.addr == `POVC_OFS_TRIM);
  assign wr_prog_reset = reg_req_in.wr && (reg_req_in.addr == `POVC_OFS_PROG_RESET);
  assign wr_cal_ctrl   = reg_req_in.wr && (reg_req_in.addr == `POVC_OFS_CAL_CTRL);

  assign osc_cal_enable     = osc_cal_control_reg_r[`POVC_CAL_EN_BIT];
  assign osc_cal_settle_sel = osc_cal_control_reg_r[`POVC_CAL_STL_HI:`POVC_CAL_STL_LO];
  // release of programming reset launches or skips calibration
  assign cal_start = wr_prog_reset && pll_program_reset_bit_r && !reg_req_in.wdata[0]
                     && osc_cal_enable;
  assign cal_skip  = wr_prog_reset && pll_program_reset_bit_r && !reg_req_in.wdata[0]
                     && !osc_cal_enable;
  // wait grows linearly with the settle field, never zero
  assign settle_len = 11'((32'(osc_cal_settle_sel) + 32'd1) * SETTLE_UNIT);

  // reserved bits are stored as zero, so a careless write cannot leak into them
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      override_r <= `POVC_RST_OVERRIDE;
    end else if (wr_override) begin
      override_r <= reg_req_in.wdata & 8'hbf;
    end
  end

  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pll_program_reset_bit_r <= `POVC_RST_PROG_RESET;
    end else if (wr_prog_reset) begin
      pll_program_reset_bit_r <= reg_req_in.wdata[0];
    end
  end

  // control writes are taken at any time; keeping them under reset is software's job
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      osc_cal_control_reg_r <= `POVC_RST_CAL_CTRL;
    end else if (wr_cal_ctrl) begin
      osc_cal_control_reg_r <= reg_req_in.wdata & 8'h71;
    end
  end

  // ****************************************
  // calibration engine
  // ****************************************
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_r      <= POVC_ST_IDLE;
      bit_idx_r    <= 3'h0;
      settle_cnt_r <= 11'h000;
    end else if (pll_program_reset_bit_r && !wr_prog_reset) begin
      state_r      <= POVC_ST_IDLE;
      bit_idx_r    <= 3'h0;
      settle_cnt_r <= 11'h000;
    end else begin
      case (state_r)
        POVC_ST_IDLE: begin
          if (cal_start) begin
            state_r      <= POVC_ST_SETTLE;
            bit_idx_r    <= 3'(`POVC_TRIM_MSB);
            settle_cnt_r <= settle_len;
          end
        end
        POVC_ST_SETTLE: begin
          if (settle_cnt_r == 11'h001) begin
            state_r <= POVC_ST_EVAL;
          end
          settle_cnt_r <= settle_cnt_r - 11'h001;
        end
        POVC_ST_EVAL: begin
          if (bit_idx_r == 3'h0) begin
            state_r <= POVC_ST_DONE;
          end else begin
            state_r      <= POVC_ST_SETTLE;
            bit_idx_r    <= bit_idx_r - 3'h1;
            settle_cnt_r <= settle_len;
          end
        end
        POVC_ST_DONE: begin
          state_r <= POVC_ST_DONE;
        end
        default: begin
          state_r <= POVC_ST_IDLE;
        end
      endcase
    end
  end

  // successive approximation: try each bit high, drop it if the oscillator runs fast
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      osc_freq_trim_field_r <= `POVC_RST_TRIM;
    end else if (cal_start) begin
      osc_freq_trim_field_r <= 7'h40;
    end else if (state_r == POVC_ST_EVAL) begin
      if (osc_too_fast_in) begin
        osc_freq_trim_field_r[bit_idx_r] <= 1'b0;
      end
      if (bit_idx_r != 3'h0) begin
        osc_freq_trim_field_r[bit_idx_r - 3'h1] <= 1'b1;
      end
    end else if (wr_trim && !osc_cal_busy_out) begin
      // writes during a run are dropped to protect the search
      osc_freq_trim_field_r <= reg_req_in.wdata[6:0];
    end
  end

  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      osc_cal_done_r <= 1'b0;
    // a search cut short by a fresh programming reset must not report done
    end else if ((state_r == POVC_ST_EVAL && bit_idx_r == 3'h0 && !pll_program_reset_bit_r)
                 || cal_skip) begin
      osc_cal_done_r <= 1'b1;
    end else if (pll_program_reset_bit_r || cal_start) begin
      osc_cal_done_r <= 1'b0;
    end
  end

  // ****************************************
  // pin or register control of the pll
  // ****************************************
  assign pll_cfg_override_en = override_r[`POVC_OVR_EN_BIT];
  // pin code: 00 both off, 01 c/1, 10 c/2 d/2, 11 c/4 d/4
  assign pin_c_sel = {clock_cfg_pin_1_in, clock_cfg_pin_0_in};
  assign pin_d_sel = clock_cfg_pin_1_in ? pin_c_sel : 2'(povc_pkg::POVC_REF_OFF);
  assign c_sel = pll_cfg_override_en ? override_r[`POVC_OVR_C_HI:`POVC_OVR_C_LO]
                                     : pin_c_sel;
  assign d_sel = pll_cfg_override_en ? override_r[`POVC_OVR_D_HI:`POVC_OVR_D_LO]
                                     : pin_d_sel;

  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pll_out_r <= 8'h00;
    end else begin
      pll_out_r[0]   <= pll_cfg_override_en ? override_r[`POVC_OVR_PLL_EN_BIT]
                                            : pll_enable_pin_in;
      pll_out_r[1]   <= pll_cfg_override_en ? override_r[`POVC_OVR_SE_BIT]
                                            : ref_single_ended_pin_in;
      pll_out_r[3:2] <= c_sel;
      pll_out_r[5:4] <= (c_sel == 2'(povc_pkg::POVC_REF_OFF)) ?
                        2'(povc_pkg::POVC_REF_OFF) : d_sel;
      pll_out_r[7:6] <= 2'b00;
    end
  end

  // ****************************************
  // read back
  // ****************************************
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rdata_r <= 8'h00;
    end else if (reg_req_in.rd) begin
      case (reg_req_in.addr)
        `POVC_OFS_OVERRIDE:   rdata_r <= override_r;
        `POVC_OFS_TRIM:       rdata_r <= {1'b0, osc_freq_trim_field_r};
        `POVC_OFS_PROG_RESET: rdata_r <= {7'h00, pll_program_reset_bit_r};
        `POVC_OFS_CAL_CTRL:   rdata_r <= osc_cal_control_reg_r;
        `POVC_OFS_CAL_STATUS: rdata_r <= {7'h00, osc_cal_done_r};
        default:              rdata_r <= 8'h00;
      endcase
    end
  end

  assign reg_rdata_out            = rdata_r;
  assign pll_enable_out           = pll_out_r[0];
  assign ref_single_ended_sel_out = pll_out_r[1];
  assign ref_out_c_div_sel_out    = pll_out_r[3:2];
  assign ref_out_d_div_sel_out    = pll_out_r[5:4];
  assign osc_freq_trim_out        = osc_freq_trim_field_r;
  assign pll_program_reset_out    = pll_program_reset_bit_r;
  assign osc_cal_busy_out         = (state_r == POVC_ST_SETTLE) || (state_r == POVC_ST_EVAL);
  assign osc_cal_done_out         = osc_cal_done_r;

endmodule
`default_nettype wire

/* test/povc_ctrl_asserts.sv */
// Purpose: port checker for povc_ctrl
// Assumes: shadows follow writes to 0x58 and 0x5d
// Notes:   shadows drop reserved bits as stored
`timescale 1ns/1ps
`default_nettype none
module povc_asserts (
  input wire logic                clock_in,
  input wire logic                resetn_in,
  input wire povc_pkg::povc_req_s reg_req_in,
  input wire logic [7:0]          reg_rdata_out,
  input wire logic                pll_enable_pin_in,
  input wire logic                ref_single_ended_pin_in,
  input wire logic                clock_cfg_pin_0_in,
  input wire logic                clock_cfg_pin_1_in,
  input wire logic                osc_too_fast_in,
  input wire logic                pll_enable_out,
  input wire logic                ref_single_ended_sel_out,
  input wire logic [1:0]          ref_out_c_div_sel_out,
  input wire logic [1:0]          ref_out_d_div_sel_out,
  input wire logic [6:0]          osc_freq_trim_out,
  input wire logic                pll_program_reset_out,
  input wire logic                osc_cal_busy_out,
  input wire logic                osc_cal_done_out
);
  logic [7:0] ovr_r, cal_r;
  logic [9:0] run_r;
  logic [1:0] c_exp, d_exp;
  logic       en_exp, se_exp;
  int         per;
  // ****************
  // shadow state
  // ****************
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ovr_r <= 8'h00;
      cal_r <= 8'h40;
    end else if (reg_req_in.wr && reg_req_in.addr == 8'h58) begin
      ovr_r <= reg_req_in.wdata & 8'hbf;
    end else if (reg_req_in.wr && reg_req_in.addr == 8'h5d) begin
      cal_r <= reg_req_in.wdata & 8'h71;
    end
  end
  // run length of the search, cleared whenever idle
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) run_r <= 10'h000;
    else run_r <= osc_cal_busy_out ? run_r + 10'h001 : 10'h000;
  end
  assign en_exp = ovr_r[7] ? ovr_r[0] : pll_enable_pin_in;
  assign se_exp = ovr_r[7] ? ovr_r[1] : ref_single_ended_pin_in;
  assign c_exp = ovr_r[7] ? ovr_r[3:2] : {clock_cfg_pin_1_in, clock_cfg_pin_0_in};
  assign d_exp = (c_exp == 2'h0) ? 2'h0 : ovr_r[7] ? ovr_r[5:4] : clock_cfg_pin_1_in ? c_exp : 2'h0;
  assign per = 7 * ((int'(cal_r[6:4]) + 1) * 10 + 1);
  // ****************
  // checks
  // ****************
  default clocking @(posedge clock_in); endclocking
  default disable iff (!resetn_in);
  a_pin_or_reg: assert property ($past(resetn_in) |->
    {pll_enable_out, ref_single_ended_sel_out} == {$past(en_exp), $past(se_exp)})
    else $error("enable or reference select wrong");
  a_c_select: assert property ($past(resetn_in) |->
    ref_out_c_div_sel_out == $past(c_exp)) else $error("c select wrong");
  a_d_select: assert property ($past(resetn_in) |->
    ref_out_d_div_sel_out == $past(d_exp)) else $error("d select wrong");
  a_d_needs_c: assert property (ref_out_c_div_sel_out == 2'h0 |->
    ref_out_d_div_sel_out == 2'h0) else $error("d clocks without c");
  a_idle_in_reset: assert property ($past(pll_program_reset_out) &&
    pll_program_reset_out |-> !osc_cal_busy_out && !osc_cal_done_out)
    else $error("engine active under program reset");
  a_cal_start: assert property ($fell(pll_program_reset_out) && cal_r[0] |->
    ##[0:1] (osc_cal_busy_out && osc_freq_trim_out == 7'h40)) else $error("search not started");
  a_skip_done: assert property ($fell(pll_program_reset_out) && !cal_r[0] |->
    ##[0:1] osc_cal_done_out) else $error("skip did not set done");
  a_run_length: assert property ($fell(osc_cal_busy_out) && !pll_program_reset_out |->
    osc_cal_done_out && run_r == per) else $error("search length or done wrong");
  a_trim_write: assert property (reg_req_in.wr && reg_req_in.addr == 8'h59 &&
    !osc_cal_busy_out |=> osc_freq_trim_out == $past(reg_req_in.wdata[6:0]))
    else $error("trim write lost");
endmodule
bind povc_ctrl povc_asserts u_chk (.*);
`default_nettype wire

/* test/test_povc_ctrl.sv */
// Purpose: self-checking bench for povc_ctrl
// Assumes: comparator modelled from a target trim
// Notes:   override codes swept against random pins
`timescale 1ns/1ps
`default_nettype none
module test_povc_ctrl;
  logic                clock_in = 1'b0;
  logic                resetn_in = 1'b0;
  logic                too_fast = 1'b0;
  logic                rd_seen = 1'b0;
  logic [3:0]          pins = 4'h0;
  povc_pkg::povc_req_s req = '0;
  logic [7:0]          rdata, v;
  logic [6:0]          trim;
  logic [6:0]          tgt = 7'h00;
  logic [1:0]          c_sel, d_sel, ce;
  logic                pll_en, se_sel, prst, busy, done;
  logic [31:0]         seed = 32'h54;
  logic [7:0]          q[$];
  logic [15:0]         rv[6] = '{16'h5800, 16'h5900, 16'h5c00, 16'h5d40, 16'h5e00, 16'h1000};
  int                  num_errors = 0;
  int                  checked = 0;
  int                  cyc = 0;
  int                  nbusy = 0;
  povc_ctrl DUT (.clock_in(clock_in), .resetn_in(resetn_in), .reg_req_in(req),
    .reg_rdata_out(rdata), .pll_enable_pin_in(pins[3]), .ref_single_ended_pin_in(pins[2]),
    .clock_cfg_pin_0_in(pins[0]), .clock_cfg_pin_1_in(pins[1]), .osc_too_fast_in(too_fast),
    .pll_enable_out(pll_en), .ref_single_ended_sel_out(se_sel), .ref_out_c_div_sel_out(c_sel),
    .ref_out_d_div_sel_out(d_sel), .osc_freq_trim_out(trim), .pll_program_reset_out(prst),
    .osc_cal_busy_out(busy), .osc_cal_done_out(done));
  // ****************
  // clock, monitor, watchdog
  // ****************
  initial begin
    forever #50 clock_in = ~clock_in;
  end
  always @(posedge clock_in) rd_seen <= req.rd;
  always @(negedge clock_in) begin
    too_fast <= trim > tgt;
    nbusy <= nbusy + int'(busy);
    if (rd_seen) chk("read data", {8'h00, q.pop_front()}, {8'h00, rdata});
  end
  always @(posedge clock_in) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      num_errors++;
      close_out();
    end
  end
  task automatic chk(input string s, input logic [15:0] e, input logic [15:0] g);
    checked++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected %s: expected %h, seen %h", s, e, g);
    end
  endtask
  // a gap cycle after each request keeps one assignment per step
  task automatic op(input logic w, input logic [7:0] a, input logic [7:0] d);
    if (!w) q.push_back(d);
    req <= '{w, !w, a, w ? d : 8'h00};
    @(negedge clock_in);
    req <= '0;
    @(negedge clock_in);
  endtask
  function automatic logic [7:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction
  task automatic close_out();
    if (num_errors == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // one trim search; ab raises program reset mid-run
  task automatic cal(input logic [7:0] ctl, input logic [6:0] et, input logic ab);
    int b, e;
    tgt = et;
    op(1'b1, 8'h5c, 8'h01);
    chk("idle", 16'h0000, {14'h0000, busy, done});
    op(1'b1, 8'h5d, ctl);
    b = nbusy;
    e = ctl[0] ? 7 * ((int'(ctl[6:4]) + 1) * 10 + 1) : 0;
    op(1'b1, 8'h5c, 8'h00);
    if (ab) begin
      repeat (100) @(negedge clock_in);
      op(1'b1, 8'h5c, 8'h01);
      chk("abort", 16'h0000, {14'h0000, busy, done});
    end else begin
      for (int n = 0; n < 1000 && done !== 1'b1; n++)
        @(negedge clock_in);
      chk("busy cycles", 16'(e), 16'(nbusy - b));
      op(1'b0, 8'h5e, 8'h01);
      op(1'b0, 8'h59, {1'b0, et});
    end
  endtask
  initial begin
    repeat (16) @(negedge clock_in);
    resetn_in <= 1'b1;
    foreach (rv[k]) op(1'b0, rv[k][15:8], rv[k][7:0]);
    for (int i = 0; i < 32; i++) begin
      v = rnd();
      pins <= v[3:0];
      op(1'b1, 8'h58, {i[4], 1'b0, i[3:0], v[5:4]});
      ce = i[4] ? i[1:0] : v[1:0];
      chk("enables", {14'h0000, i[4] ? {v[4], v[5]} : v[3:2]}, {14'h0000, pll_en, se_sel});
      chk("c select", {14'h0000, ce}, {14'h0000, c_sel});
      chk("d select", {14'h0000, ce == 2'h0 ? 2'h0 : i[4] ? i[3:2] : v[1] ? ce : 2'h0}, {14'h0000, d_sel});
    end
    op(1'b1, 8'h58, 8'hff);
    op(1'b0, 8'h58, 8'hbf);
    op(1'b1, 8'h59, 8'h2a);
    op(1'b0, 8'h59, 8'h2a);
    op(1'b1, 8'h5c, 8'hff);
    op(1'b0, 8'h5c, 8'h01);
    op(1'b1, 8'h5d, 8'hff);
    op(1'b0, 8'h5d, 8'h71);
    cal(8'h40, 7'h2a, 1'b0);
    v = rnd();
    cal(8'h01, v[6:0], 1'b0);
    v = rnd();
    cal(8'h41, v[6:0], 1'b0);
    cal(8'h71, 7'h7f, 1'b0);
    cal(8'h71, 7'h00, 1'b1);
    close_out();
  end
endmodule
`default_nettype wire
